// File: inc/ether_mode_params.svh
`ifndef ETHER_MODE_PARAMS_SVH
`define ETHER_MODE_PARAMS_SVH

// register byte offsets
`define EM_CTRL_OFS        8'h00
`define EM_GPIO_OUT_OFS    8'h04
`define EM_GPIO_DIR_OFS    8'h08
`define EM_STATUS_OFS      8'h0c
`define EM_ADDR_OFS        8'h10
// control register fields
`define EM_CTRL_IFSEL_BIT  0
`define EM_CTRL_REFDRV_BIT 1
`define EM_CTRL_SEC_LSB    8
`define EM_CTRL_RESET      32'h0000_0000
// status register fields
`define EM_ST_OVF_BIT      0
`define EM_ST_MODE_LSB     4
`define EM_ST_STRAP_LSB    8
`define EM_ST_DONE_BIT     10
`define EM_ST_GPIN_LSB     16
// management addresses
`define EM_EMBED_PHY_ADDR  5'h10
// strap settle count, cycles after reset release
`define EM_STRAP_WAIT      2'd2
`endif

// File: inc/ether_mode_pkg.sv
package ether_mode_pkg;
    // media setup chosen by the straps
    typedef enum logic [1:0]
    {
        MODE_MAC_EMBED,
        MODE_MAC_RMII,
        MODE_PHY_RRMII
    } mode_t;

    // one transmit dibit with its enable
    typedef struct packed
    {
        logic       en;
        logic [1:0] d;
    } tx_dibit_t;

    // one receive dibit with carrier/valid
    typedef struct packed
    {
        logic       crs_dv;
        logic [1:0] d;
    } rx_dibit_t;
endpackage

// File: hw/ether_mode_pin_mux.sv
`include "ether_mode_params.svh"

// ---------------------------------------------------------------
// receive buffer
// ---------------------------------------------------------------
module ether_mode_fifo
    import ether_mode_pkg::*;
#(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and level update
    always_comb
    begin
        wr_next  = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
        rd_next  = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage carries no reset; only written entries are read
    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem_reg[wr_reg] <= in_data;
    end
endmodule

// ---------------------------------------------------------------
// operating role and media pin mux
// ---------------------------------------------------------------
module ether_mode_pin_mux
    import ether_mode_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // strap pins
    input  wire logic        rmii_select_strap,
    input  wire logic        role_select_strap,
    // multi-function pins, enables low while driving
    input  wire logic [7:0]  group_b_in,
    output logic [7:0]       group_b_out,
    output logic [7:0]       group_b_oe_n,
    input  wire logic [1:0]  group_a_in,
    output logic [1:0]       group_a_out,
    output logic [1:0]       group_a_oe_n,
    // mac core side
    input  wire tx_dibit_t   mac_tx,
    input  wire logic        mac_mdc,
    input  wire logic        mac_mdio_out,
    input  wire logic        mac_mdio_oe_n,
    input  wire logic [4:0]  mac_mgmt_addr,
    output logic             mac_mdin,
    output logic             mac_rx_valid,
    output logic [1:0]       mac_rx_data,
    input  wire logic        mac_rx_ready,
    output logic             rx_fifo_ready,
    // embedded phy side
    input  wire rx_dibit_t   phy_rx,
    output tx_dibit_t        phy_tx,
    output logic             phy_mdc,
    output logic             phy_mdio_in,
    input  wire logic        phy_mdio_out,
    input  wire logic        phy_mdio_oe_n,
    // management addresses
    output logic [4:0]       ext_mgmt_address
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    logic [7:0]  b_in;
    logic [1:0]  a_in;
    logic        rmii_strap_s;
    logic        role_strap_s;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {rmii_select_strap, role_select_strap, group_a_in, group_b_in};
            sync2_reg <= sync1_reg;
        end
    end
    assign {rmii_strap_s, role_strap_s, a_in, b_in} = sync2_reg;

    // ---------------------------------------------------------------
    // strap capture
    // ---------------------------------------------------------------
    logic [1:0] strap_cnt_reg;
    logic [1:0] strap_cnt_next;
    logic       strap_done_reg;
    logic       strap_done_next;
    mode_t      mode_reg;
    mode_t      mode_next;

    // wait for the synchroniser to fill, then latch once
    always_comb
    begin
        strap_cnt_next  = strap_cnt_reg;
        strap_done_next = strap_done_reg;
        mode_next       = mode_reg;
        if (!strap_done_reg)
        begin
            if (strap_cnt_reg == `EM_STRAP_WAIT)
            begin
                strap_done_next = 1'b1;
                if (rmii_strap_s)
                    mode_next = MODE_MAC_EMBED;
                else if (role_strap_s)
                    mode_next = MODE_MAC_RMII;
                else
                    mode_next = MODE_PHY_RRMII;
            end
            else
                strap_cnt_next = strap_cnt_reg + 2'd1;
        end
    end

    // held until the next reset, the strap pins are free afterwards
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            strap_cnt_reg  <= '0;
            strap_done_reg <= 1'b0;
            mode_reg       <= MODE_MAC_EMBED;
        end
        else
        begin
            strap_cnt_reg  <= strap_cnt_next;
            strap_done_reg <= strap_done_next;
            mode_reg       <= mode_next;
        end
    end

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [7:0]  gpio_out_reg;
    logic [7:0]  gpio_out_next;
    logic [7:0]  gpio_dir_reg;
    logic [7:0]  gpio_dir_next;
    logic        ovf_reg;
    logic        ovf_next;
    logic        wait_reg;
    logic        wait_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        wr_take;
    logic        fifo_in_ready;
    logic        rx_push;
    logic        use_pins;
    logic [4:0]  ext_addr;

    assign wr_take = write && !wait_reg;

    // one wait state per access; read data prepared meanwhile
    always_comb
    begin
        wait_next     = !((read || write) && wait_reg);
        rdata_next    = rdata_reg;
        ctrl_next     = ctrl_reg;
        gpio_out_next = gpio_out_reg;
        gpio_dir_next = gpio_dir_reg;
        ovf_next      = ovf_reg;
        if (read && wait_reg)
        begin
            case (address)
                `EM_CTRL_OFS:     rdata_next = ctrl_reg;
                `EM_GPIO_OUT_OFS: rdata_next = {24'h0, gpio_out_reg};
                `EM_GPIO_DIR_OFS: rdata_next = {24'h0, gpio_dir_reg};
                `EM_STATUS_OFS:
                begin
                    rdata_next                         = '0;
                    rdata_next[`EM_ST_OVF_BIT]         = ovf_reg;
                    rdata_next[`EM_ST_MODE_LSB +: 2]   = mode_reg;
                    rdata_next[`EM_ST_STRAP_LSB +: 2]  = {rmii_strap_s, role_strap_s};
                    rdata_next[`EM_ST_DONE_BIT]        = strap_done_reg;
                    rdata_next[`EM_ST_GPIN_LSB +: 8]   = b_in;
                end
                `EM_ADDR_OFS:     rdata_next = {19'h0, ext_addr, 3'h0, `EM_EMBED_PHY_ADDR};
                default:          rdata_next = '0;
            endcase
        end
        if (wr_take)
        begin
            case (address)
                `EM_CTRL_OFS:     ctrl_next     = writedata;
                `EM_GPIO_OUT_OFS: gpio_out_next = writedata[7:0];
                `EM_GPIO_DIR_OFS: gpio_dir_next = writedata[7:0];
                `EM_STATUS_OFS:
                    if (writedata[`EM_ST_OVF_BIT])
                        ovf_next = 1'b0;
                default:          ;
            endcase
        end
        // a dropped dibit in the clearing cycle still sets the flag
        if (rx_push && !fifo_in_ready)
            ovf_next = 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_reg     <= 1'b1;
            rdata_reg    <= '0;
            ctrl_reg     <= `EM_CTRL_RESET;
            gpio_out_reg <= '0;
            gpio_dir_reg <= '0;
            ovf_reg      <= 1'b0;
        end
        else
        begin
            wait_reg     <= wait_next;
            rdata_reg    <= rdata_next;
            ctrl_reg     <= ctrl_next;
            gpio_out_reg <= gpio_out_next;
            gpio_dir_reg <= gpio_dir_next;
            ovf_reg      <= ovf_next;
        end
    end
    assign waitrequest = wait_reg;
    assign readdata    = rdata_reg;

    // ---------------------------------------------------------------
    // path selection and management addressing
    // ---------------------------------------------------------------
    // pins only once straps are known; embedded otherwise
    assign use_pins = strap_done_reg &&
                      ((mode_reg == MODE_PHY_RRMII) ||
                       (mode_reg == MODE_MAC_RMII && ctrl_reg[`EM_CTRL_IFSEL_BIT]));
    assign ext_addr = (mode_reg == MODE_PHY_RRMII) ?
                      {ctrl_reg[`EM_CTRL_SEC_LSB+1 +: 4], 1'b0} :
                      ctrl_reg[`EM_CTRL_SEC_LSB +: 5];

    // ---------------------------------------------------------------
    // pin mux
    // ---------------------------------------------------------------
    logic [7:0] b_out_next;
    logic [7:0] b_oe_n_next;
    logic [1:0] a_out_next;
    logic [1:0] a_oe_n_next;
    logic [7:0] b_out_reg;
    logic [7:0] b_oe_n_reg;
    logic [1:0] a_out_reg;
    logic [1:0] a_oe_n_reg;
    logic       phase_reg;
    rx_dibit_t  pin_rx;
    rx_dibit_t  sel_rx;
    tx_dibit_t  phy_tx_next;
    tx_dibit_t  phy_tx_reg;
    logic       mdin_next;
    logic       mdin_reg;
    logic       pmdc_next;
    logic       pmdc_reg;
    logic       pmdio_next;
    logic       pmdio_reg;
    logic       rmii_mode;

    assign rmii_mode = strap_done_reg && (mode_reg != MODE_MAC_EMBED);

    // receive dibit as seen on the pins in either rmii role
    always_comb
    begin
        if (mode_reg == MODE_PHY_RRMII)
            pin_rx = '{crs_dv: b_in[1], d: {b_in[6], b_in[7]}};
        else
            pin_rx = '{crs_dv: b_in[1], d: {b_in[6], b_in[7]}};
        sel_rx = use_pins ? pin_rx : phy_rx;
    end

    // per-mode pin directions and values
    always_comb
    begin
        b_out_next  = gpio_out_reg;
        b_oe_n_next = ~gpio_dir_reg;
        a_out_next  = '0;
        a_oe_n_next = 2'b11;
        phy_tx_next = use_pins ? tx_dibit_t'('0) : mac_tx;
        pmdc_next   = mac_mdc;
        pmdio_next  = mac_mdio_oe_n ? 1'b1 : mac_mdio_out;
        mdin_next   = (mac_mgmt_addr == `EM_EMBED_PHY_ADDR) ?
                      phy_mdio_out : a_in[1];
        if (rmii_mode)
        begin
            b_oe_n_next[7:1] = 7'h7f;
            b_out_next[7:1]  = '0;
            // gated so only the active path reaches the pins
            if (use_pins)
            begin
                b_out_next[4:2]  = mode_reg == MODE_PHY_RRMII ?
                                   {mac_tx.d[0], mac_tx.d[1], mac_tx.en} :
                                   {mac_tx.d[0], mac_tx.d[1], mac_tx.en};
                b_oe_n_next[4:2] = 3'b000;
            end
            // divide the 100 MHz clock by two when driving
            if (ctrl_reg[`EM_CTRL_REFDRV_BIT])
            begin
                b_out_next[5]  = ~b_out_reg[5];
                b_oe_n_next[5] = 1'b0;
            end
            if (mode_reg == MODE_PHY_RRMII)
            begin
                // external mac is master; embedded phy answers at 10h
                pmdc_next      = a_in[0];
                pmdio_next     = a_in[1];
                a_out_next[1]  = phy_mdio_out;
                a_oe_n_next[1] = phy_mdio_oe_n;
                mdin_next      = 1'b1;
            end
            else
            begin
                a_out_next     = {mac_mdio_out, mac_mdc};
                a_oe_n_next    = {mac_mdio_oe_n, 1'b0};
            end
        end
        b_out_next[0]  = gpio_out_reg[0];
        b_oe_n_next[0] = ~gpio_dir_reg[0];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            b_out_reg  <= '0;
            b_oe_n_reg <= 8'hff;
            a_out_reg  <= '0;
            a_oe_n_reg <= 2'b11;
            phy_tx_reg <= '0;
            mdin_reg   <= 1'b1;
            pmdc_reg   <= 1'b0;
            pmdio_reg  <= 1'b1;
            phase_reg  <= 1'b0;
        end
        else
        begin
            b_out_reg  <= b_out_next;
            b_oe_n_reg <= b_oe_n_next;
            a_out_reg  <= a_out_next;
            a_oe_n_reg <= a_oe_n_next;
            phy_tx_reg <= phy_tx_next;
            mdin_reg   <= mdin_next;
            pmdc_reg   <= pmdc_next;
            pmdio_reg  <= pmdio_next;
            phase_reg  <= ~phase_reg;
        end
    end

    // ---------------------------------------------------------------
    // receive buffer toward the mac
    // ---------------------------------------------------------------
    // one sample per 50 MHz period; phase is local, not locked to the pin
    assign rx_push = sel_rx.crs_dv && phase_reg;

    ether_mode_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) rx_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (rx_push),
        .in_data   (sel_rx.d),
        .in_ready  (fifo_in_ready),
        .out_valid (mac_rx_valid),
        .out_data  (mac_rx_data),
        .out_ready (mac_rx_ready)
    );

    logic fifo_rdy_reg;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            fifo_rdy_reg <= 1'b0;
        else
            fifo_rdy_reg <= fifo_in_ready;
    end

    assign group_b_out      = b_out_reg;
    assign group_b_oe_n     = b_oe_n_reg;
    assign group_a_out      = a_out_reg;
    assign group_a_oe_n     = a_oe_n_reg;
    assign phy_tx           = phy_tx_reg;
    assign mac_mdin         = mdin_reg;
    assign phy_mdc          = pmdc_reg;
    assign phy_mdio_in      = pmdio_reg;
    assign rx_fifo_ready    = fifo_rdy_reg;
    assign ext_mgmt_address = ctrl_reg[`EM_CTRL_SEC_LSB +: 5];
endmodule

// File: test/ether_mode_pin_mux_asserts.sv
// ---------------------------------------------------------------
// port checker for the media pin mux
// ---------------------------------------------------------------
module ether_mode_pin_mux_chk
    import ether_mode_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       read,
    input wire logic       write,
    input wire logic       waitrequest,
    input wire logic [7:0] group_b_out,
    input wire logic [7:0] group_b_oe_n,
    input wire logic [1:0] group_a_out,
    input wire logic [1:0] group_a_oe_n,
    input wire tx_dibit_t  mac_tx,
    input wire logic       mac_mdc,
    input wire logic       mac_mdio_oe_n,
    input wire logic [4:0] mac_mgmt_addr,
    input wire logic       mac_mdin,
    input wire logic       mac_rx_valid,
    input wire logic [1:0] mac_rx_data,
    input wire logic       mac_rx_ready,
    input wire logic       rx_fifo_ready,
    input wire tx_dibit_t  phy_tx,
    input wire logic       phy_mdio_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // bus answers after exactly one wait cycle
    wait_answer_a: assert property (
        (read || write) && waitrequest |=> !waitrequest) else $error("bus answer late");
    wait_pulse_a: assert property (
        !waitrequest |=> waitrequest) else $error("waitrequest low too long");
    wait_cause_a: assert property (
        $fell(waitrequest) |-> $past(read || write)) else $error("answer without request");
    // driven reference clock halves the 100 MHz source
    ref_toggle_a: assert property (
        !group_b_oe_n[5] ##1 !group_b_oe_n[5] |-> group_b_out[5] != $past(group_b_out[5]))
        else $error("ref clock not toggling");
    // mdc output marks mac over rmii: receive pins stay inputs
    rmii_inputs_a: assert property (
        !group_a_oe_n[0] |-> group_b_oe_n[1] && group_b_oe_n[7:6] == 2'b11) else $error("rx pin driven");
    mgmt_fwd_a: assert property (
        !group_a_oe_n[0] ##1 !group_a_oe_n[0] |-> group_a_out[0] == $past(mac_mdc)
        && group_a_oe_n[1] == $past(mac_mdio_oe_n)) else $error("mgmt pins not forwarded");
    embed_tx_a: assert property (
        phy_tx != '0 |-> phy_tx == $past(mac_tx)) else $error("embedded tx wrong");
    mdin_embed_a: assert property (
        !group_a_oe_n[0] && mac_mgmt_addr == 5'h10 |=> mac_mdin == $past(phy_mdio_out))
        else $error("mdin not from embedded phy");
    fifo_hold_a: assert property (
        mac_rx_valid && !mac_rx_ready |=> mac_rx_valid && $stable(mac_rx_data)) else $error("rx head lost");
    full_valid_a: assert property (
        $fell(rx_fifo_ready) |-> mac_rx_valid) else $error("full while empty");
endmodule

bind ether_mode_pin_mux ether_mode_pin_mux_chk chk_u (.ref_clk(ref_clk), .rst(rst), .read(read),
    .write(write), .waitrequest(waitrequest), .group_b_out(group_b_out), .group_b_oe_n(group_b_oe_n),
    .group_a_out(group_a_out), .group_a_oe_n(group_a_oe_n), .mac_tx(mac_tx), .mac_mdc(mac_mdc),
    .mac_mdio_oe_n(mac_mdio_oe_n), .mac_mgmt_addr(mac_mgmt_addr), .mac_mdin(mac_mdin),
    .mac_rx_valid(mac_rx_valid), .mac_rx_data(mac_rx_data), .mac_rx_ready(mac_rx_ready),
    .rx_fifo_ready(rx_fifo_ready), .phy_tx(phy_tx), .phy_mdio_out(phy_mdio_out));

// File: test/ext_phy_model.sv
// ---------------------------------------------------------------
// external rmii phy facing the mac-role pins
// ---------------------------------------------------------------
module ext_phy_model
(
    input  wire logic       ref_clk,
    input  wire logic       send,
    input  wire logic [1:0] rx_val,
    input  wire logic       tx_en_pin,
    output logic            crs_dv,
    output logic [1:0]      rxd,
    output logic            tx_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // crs_dv driven low between frames; data lines released flip each cycle
    always @(posedge ref_clk)
    begin
        crs_dv <= send;
        rxd    <= send ? rx_val : ~rxd;
        if (tx_en_pin === 1'b1)
            tx_seen <= 1'b1;
    end

    initial
    begin
        crs_dv  = 1'b0;
        rxd     = 2'b00;
        tx_seen = 1'b0;
    end
endmodule

// File: test/testbench.sv
// ---------------------------------------------------------------
// bench for the media pin mux
// ---------------------------------------------------------------
module testbench
    import ether_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk, rst, read, write, waitrequest, rmii_s, role_s;
    logic [7:0]  address, b_in, b_out, b_oe_n, tb_pin, drv;
    logic [31:0] writedata, readdata, q;
    logic [1:0]  a_in, a_out, a_oe_n, a_pin, rx_data, rx_val, rxd;
    tx_dibit_t   mac_tx, phy_tx;
    logic        mdc, mdio_o, mdio_oe_n, mdin, rx_valid, rx_ready, fifo_rdy;
    logic        phy_mdc, phy_mdin, phy_mdo, send, crs_dv, tx_seen;
    logic [4:0]  mgmt, ext_addr;
    int          num_errors, n_checks, n;

    typedef struct packed
    {
        logic        rmii, role;
        logic [31:0] ctrl;
        logic [1:0]  mode;
        logic [7:0]  oe_n;
        logic        a0_oe_n;
        logic [31:0] addr;
    } row_t;
    row_t rows [4] = '{
        '{1'b1, 1'b1, 32'h0000_1f00, 2'h0, 8'hff, 1'b1, 32'h0000_1f10},
        '{1'b1, 1'b0, 32'h0000_0300, 2'h0, 8'hff, 1'b1, 32'h0000_0310},
        '{1'b0, 1'b0, 32'h0000_0b00, 2'h2, 8'he3, 1'b1, 32'h0000_0a10},
        '{1'b0, 1'b1, 32'h0000_0b03, 2'h1, 8'hc3, 1'b0, 32'h0000_0b10}};

    ether_mode_pin_mux #(.FIFO_DEPTH(4)) dut_u (.ref_clk(ref_clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rmii_select_strap(rmii_s), .role_select_strap(role_s),
        .group_b_in(b_in), .group_b_out(b_out), .group_b_oe_n(b_oe_n), .group_a_in(a_in),
        .group_a_out(a_out), .group_a_oe_n(a_oe_n), .mac_tx(mac_tx), .mac_mdc(mdc),
        .mac_mdio_out(mdio_o), .mac_mdio_oe_n(mdio_oe_n), .mac_mgmt_addr(mgmt), .mac_mdin(mdin),
        .mac_rx_valid(rx_valid), .mac_rx_data(rx_data), .mac_rx_ready(rx_ready),
        .rx_fifo_ready(fifo_rdy), .phy_rx(3'b000), .phy_tx(phy_tx), .phy_mdc(phy_mdc),
        .phy_mdio_in(phy_mdin), .phy_mdio_out(phy_mdo), .phy_mdio_oe_n(1'b1),
        .ext_mgmt_address(ext_addr));

    ext_phy_model phy_u (.ref_clk(ref_clk), .send(send), .rx_val(rx_val), .tx_en_pin(b_out[2]),
        .crs_dv(crs_dv), .rxd(rxd), .tx_seen(tx_seen));

    // far side only wired up in mac-over-rmii strap setup
    always_comb
    begin
        drv = (!rmii_s && role_s) ? {rxd[0], rxd[1], tb_pin[5:2], crs_dv, tb_pin[0]} : tb_pin;
        for (int i = 0; i < 8; i++)
            b_in[i] = !b_oe_n[i] ? b_out[i] : drv[i];
        for (int i = 0; i < 2; i++)
            a_in[i] = !a_oe_n[i] ? a_out[i] : a_pin[i];
    end

    // ---------------------------------------------------------------
    // clock, compare, bus and reset tasks
    // ---------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one avalon access; an idle edge after release keeps strobes single-driven
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 40);
        q = readdata;
        if (k >= 40)
            check(0, 1, "bus hang");
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic do_reset(input logic r, input logic p);
        rmii_s <= r;
        role_s <= p;
        rst    <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        q = '0;
        for (int k = 0; k < 20 && q[10] !== 1'b1; k++)
            bus(0, 8'h0c, 0);
        check(q[10], 1, "straps captured");
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        {rst, read, write, address, writedata, rmii_s, role_s} = {1'b1, 44'd0};
        {mac_tx, mdc, mdio_o, mdio_oe_n, mgmt, rx_ready, phy_mdo} = 13'h0020;
        {tb_pin, a_pin, send, rx_val, num_errors, n_checks} = '0;
        // strap setups as table rows
        foreach (rows[i])
        begin
            do_reset(rows[i].rmii, rows[i].role);
            bus(0, 8'h00, 0);
            check(q, 0, "ctrl reset");
            bus(1, 8'h00, rows[i].ctrl);
            repeat (3) @(posedge ref_clk);
            bus(0, 8'h0c, 0);
            check(q[5:4], rows[i].mode, "mode");
            check(q[9:8], {rows[i].rmii, rows[i].role}, "straps");
            check(b_oe_n, rows[i].oe_n, "b dirs");
            check(a_oe_n[0], rows[i].a0_oe_n, "mdc dir");
            bus(0, 8'h10, 0);
            check(q, rows[i].addr, "mgmt addr");
            check(ext_addr, rows[i].ctrl[12:8], "sec addr");
            $display("row %0d done", i);
        end
        // straps moved after capture have no effect
        rmii_s <= 1'b1;
        role_s <= 1'b0;
        repeat (6) @(posedge ref_clk);
        bus(0, 8'h0c, 0);
        check(q[5:4], 1, "mode held");
        {rmii_s, role_s} <= 2'b01;
        // transmit on pins, then on embedded path
        mac_tx <= 3'b110;
        repeat (3) @(posedge ref_clk);
        check(b_out[4:2], 3'b011, "tx pins");
        check(phy_tx, 0, "embed idle");
        check(tx_seen, 1, "phy took tx");
        bus(1, 8'h00, 32'h0000_0b02);
        mac_tx <= 3'b101;
        repeat (3) @(posedge ref_clk);
        check(phy_tx, 3'b101, "embed tx");
        bus(1, 8'h00, 32'h0000_0b03);
        $display("tx test done");
        // management: pins out, read data source by address
        {mdc, mdio_o, mdio_oe_n, phy_mdo, mgmt} <= {4'b1101, 5'h03};
        repeat (3) @(posedge ref_clk);
        check({a_out, a_oe_n, phy_mdc, phy_mdin}, 6'b110011, "mgmt out");
        mdio_oe_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check(mdin, 0, "ext mdio");
        mgmt <= 5'h10;
        repeat (3) @(posedge ref_clk);
        check(mdin, 1, "embed mdio");
        $display("mgmt test done");
        // pin 0 stays gpio inside rmii setup
        bus(1, 8'h08, 32'h0000_00ff);
        bus(1, 8'h04, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
        check({b_oe_n[7:6], b_oe_n[0], b_out[0]}, 4'b1101, "pin0 gpio");
        bus(1, 8'h08, 0);
        // receive fills while the mac stalls
        {send, rx_val} <= 3'b110;
        repeat (40) @(posedge ref_clk);
        check(fifo_rdy, 0, "fifo full");
        send <= 1'b0;
        repeat (4) @(posedge ref_clk);
        bus(0, 8'h0c, 0);
        check(q[0], 1, "overflow");
        rx_ready <= 1'b1;
        n = 0;
        repeat (12)
        begin
            @(posedge ref_clk);
            if (rx_valid === 1'b1)
            begin
                n++;
                check(rx_data, 2'b10, "rx data");
            end
        end
        check(n, 4, "drained");
        bus(1, 8'h0c, 1);
        bus(0, 8'h0c, 0);
        check(q[0], 0, "overflow clear");
        // unmapped place reads zero and writes vanish
        bus(1, 8'h40, 32'hffff_ffff);
        bus(0, 8'h40, 0);
        check(q, 0, "unmapped");
        bus(0, 8'h00, 0);
        check(q, 32'h0000_0b03, "ctrl kept");
        $display("rx and bus test done");
        // all-gpio setup: half the pins driven, half read back
        do_reset(1'b1, 1'b1);
        bus(1, 8'h08, 32'h0000_000f);
        bus(1, 8'h04, 32'h0000_00a5);
        tb_pin <= 8'h3c;
        repeat (5) @(posedge ref_clk);
        check({b_oe_n, b_out[3:0]}, 12'hf05, "gpio out");
        bus(0, 8'h0c, 0);
        check(q[23:16], 8'h35, "gpio in");
        $display("gpio test done");
        close_out;
    end

    // hang guard, well past the run
    initial
    begin
        #100us;
        num_errors++;
        close_out;
    end
endmodule
